// >>> shared/tmrsq_regs.vh
// register offsets, field positions, reset values and prescaler counts of the timer group
`ifndef TMRSQ_REGS_VH
`define TMRSQ_REGS_VH

// ==========================================
// register byte offsets
`define TMRSQ_CTRL        8'h00
`define TMRSQ_CMP         8'h04
`define TMRSQ_FRC_LO      8'h08
`define TMRSQ_FRC_HI      8'h0C
`define TMRSQ_FRC_W       8'h10
`define TMRSQ_STATUS      8'h14
`define TMRSQ_IST         8'h18
`define TMRSQ_MASK        8'h1C

// ==========================================
// control register fields
`define TMRSQ_EN_A        0
`define TMRSQ_OE_A        1
`define TMRSQ_SEL_A       4:2
`define TMRSQ_EN_B        5
`define TMRSQ_SEL_B       7:6
`define TMRSQ_OE_B        8
`define TMRSQ_SEL16       10:9
`define TMRSQ_CASC        11
`define TMRSQ_CTRL_W      12
`define TMRSQ_CTRL_RST    12'h200

// ==========================================
// compare register fields and reset values
`define TMRSQ_CMP_A       7:0
`define TMRSQ_CMP_B       15:8
`define TMRSQ_CMP_RST     8'hFF
`define TMRSQ_MASK_RST    2'h0
`define TMRSQ_CNT16_RST   16'h0000
`define TMRSQ_CNT8_RST    8'h00

// ==========================================
// interrupt bits
`define TMRSQ_IRQ_A       0
`define TMRSQ_IRQ_B       1

// ==========================================
// clock select codes
`define TMRSQ_A_FX        3'h0
`define TMRSQ_A_FX8       3'h1
`define TMRSQ_A_FX128     3'h2
`define TMRSQ_A_SUB       3'h3
`define TMRSQ_A_BMATCH    3'h4
`define TMRSQ_A_BOUT      3'h5
`define TMRSQ_B_FX8       2'h0
`define TMRSQ_B_EV1       2'h1
`define TMRSQ_B_EV2       2'h2
`define TMRSQ_B_FX128     2'h3
`define TMRSQ_16_BMATCH   2'h0
`define TMRSQ_16_FX       2'h1
`define TMRSQ_16_FX8      2'h2
`define TMRSQ_16_FX128    2'h3

// ==========================================
// prescaler: fx is pclk; fx/8 and fx/128 are enable pulses
`define TMRSQ_DIV8_MASK   7'h07
`define TMRSQ_DIV128_MASK 7'h7F

`endif

// >>> logic/tmrsq_top.v
// timer group: free-running 16-bit counter with read buffer, two 8-bit square-wave timers
`timescale 1ns/1ps
`include "tmrsq_regs.vh"
// ==========================================
// What this block does
// - reset clears the 16-bit counter, which then runs freely, never stopped or cleared
// - low-byte read freezes the read buffer holding the captured count
// - high-byte read completion releases the buffer back to tracking
// - counter keeps running in stop; flag marks its value undefined afterwards
// - 24-bit event mode is read-only; only its low byte, timer B, has compare, match and clear
// - square-wave mode inverts output pin on each compare match
// - match clears 8-bit counter to zero and raises interrupt one cycle later
// - clearing count enable forces square-wave output low
// - timer A clock: fx, fx/8, fx/128, subclock, B match, B output
module tmrsq_top (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire        stop_mode,
	input  wire        sub_clk_pin,
	input  wire        event_input_pin,
	output reg         square_out_pin,
	output reg         square_out_pin_b,
	output reg         irq
);

	// ==========================================
	// functions
	// one tick of an 8-bit compare timer: {match, next count}
	function [8:0] step8;
		input [7:0] cnt;
		input [7:0] cmp;
		begin
			if (cnt == cmp)
				step8 = {1'b1, `TMRSQ_CNT8_RST};
			else
				step8 = {1'b0, cnt + 8'h01};
		end
	endfunction

	// rising edge of a synchronised pin: stages two and three agree high, level was low
	function rise_tick;
		input [2:0] sync;
		input       level;
		begin
			rise_tick = (sync[1] == sync[2]) & sync[2] & ~level;
		end
	endfunction

	// settled pin level: a disagreement of stages two and three keeps the old level
	function settled;
		input [2:0] sync;
		input       level;
		begin
			settled = (sync[1] == sync[2]) ? sync[2] : level;
		end
	endfunction

	// one register selected by its offset in a given bus phase
	function hit;
		input       phase;
		input [7:0] addr;
		input [7:0] reg_off;
		begin
			hit = phase & (addr == reg_off);
		end
	endfunction

	// ==========================================
	// state
	reg [`TMRSQ_CTRL_W-1:0] ctrl;
	reg [7:0]               cmp_a;
	reg [7:0]               cmp_b;
	reg [1:0]               mask;
	reg [1:0]               ist;
	reg [15:0]              cnt16;
	reg [15:0]              rd_buf;
	reg                     frozen;
	reg [7:0]               cnt_a;
	reg [7:0]               cnt_b;
	reg                     match_a_q;
	reg                     match_b_q;
	reg [6:0]               pre;
	reg [2:0]               ev_sync;
	reg [2:0]               sub_sync;
	reg                     ev_level;
	reg                     sub_level;
	reg                     stop_q;
	reg                     undef_flag;
	reg [31:0]              rdata;
	reg                     bad_addr;
	reg                     tick_a;
	reg                     tick_b;
	reg                     tick16;

	wire        setup   = psel & ~penable;
	wire        acc     = psel & penable & pready;
	wire        wr      = acc & pwrite;
	wire        rd      = acc & ~pwrite;
	wire        div8    = ((pre & `TMRSQ_DIV8_MASK) == `TMRSQ_DIV8_MASK);
	wire        div128  = (pre == `TMRSQ_DIV128_MASK);
	wire        ev_tick = rise_tick(ev_sync, ev_level);
	wire        sb_tick = rise_tick(sub_sync, sub_level);
	wire [15:0] view    = frozen ? rd_buf : cnt16;
	wire [8:0]  nx_a    = step8(cnt_a, cmp_a);
	wire [8:0]  nx_b    = step8(cnt_b, cmp_b);
	wire        clr_ist = hit(rd, paddr, `TMRSQ_IST);
	wire        clr_und = hit(rd, paddr, `TMRSQ_STATUS);
	wire [1:0]  next_ist = (ist & ~{2{clr_ist}}) | {match_b_q, match_a_q};

	// ==========================================
	// tick selection
	always @* begin
		case (ctrl[`TMRSQ_SEL_A])
		`TMRSQ_A_FX:     tick_a = 1'b1;
		`TMRSQ_A_FX8:    tick_a = div8;
		`TMRSQ_A_FX128:  tick_a = div128;
		`TMRSQ_A_SUB:    tick_a = sb_tick;
		`TMRSQ_A_BMATCH: tick_a = match_b_q;
		`TMRSQ_A_BOUT:   tick_a = match_b_q & square_out_pin_b;
		default:         tick_a = 1'b0;
		endcase
		if (ctrl[`TMRSQ_CASC])
			tick_b = match_a_q;
		else begin
			case (ctrl[`TMRSQ_SEL_B])
			`TMRSQ_B_FX8:   tick_b = div8;
			`TMRSQ_B_EV1:   tick_b = ev_tick;
			`TMRSQ_B_EV2:   tick_b = ev_tick;
			`TMRSQ_B_FX128: tick_b = div128;
			default:        tick_b = 1'b0;
			endcase
		end
		case (ctrl[`TMRSQ_SEL16])
		`TMRSQ_16_BMATCH: tick16 = match_b_q;
		`TMRSQ_16_FX:     tick16 = 1'b1;
		`TMRSQ_16_FX8:    tick16 = div8;
		`TMRSQ_16_FX128:  tick16 = div128;
		default:          tick16 = 1'b0;
		endcase
	end

	// ==========================================
	// read mux and decode
	always @* begin
		rdata    = 32'h00000000;
		bad_addr = 1'b0;
		case (paddr)
		`TMRSQ_CTRL:   rdata[`TMRSQ_CTRL_W-1:0] = ctrl;
		`TMRSQ_CMP:    rdata[15:0] = {cmp_b, cmp_a};
		`TMRSQ_FRC_LO: rdata[7:0] = view[7:0];
		`TMRSQ_FRC_HI: rdata[7:0] = view[15:8];
		`TMRSQ_FRC_W:  rdata[15:0] = view;
		`TMRSQ_STATUS: rdata[19:0] = {undef_flag, frozen, square_out_pin_b,
			square_out_pin, cnt_b, cnt_a};
		`TMRSQ_IST:    rdata[1:0] = ist;
		`TMRSQ_MASK:   rdata[1:0] = mask;
		default:       bad_addr = 1'b1;
		endcase
	end

	// ==========================================
	// apb slave and registers
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
			ctrl    <= `TMRSQ_CTRL_RST;
			cmp_a   <= `TMRSQ_CMP_RST;
			cmp_b   <= `TMRSQ_CMP_RST;
			mask    <= `TMRSQ_MASK_RST;
		end else begin
			// zero wait states: read data is prepared during the setup cycle
			pready <= 1'b1;
			if (setup) begin
				pslverr <= bad_addr;
				prdata  <= pwrite ? 32'h00000000 : rdata;
			end else if (acc) begin
				pslverr <= 1'b0;
				prdata  <= 32'h00000000;
			end
			// writes to read-only offsets are dropped without an error
			if (hit(wr, paddr, `TMRSQ_CTRL))
				ctrl <= pwdata[`TMRSQ_CTRL_W-1:0];
			if (hit(wr, paddr, `TMRSQ_CMP)) begin
				cmp_a <= pwdata[`TMRSQ_CMP_A];
				cmp_b <= pwdata[`TMRSQ_CMP_B];
			end
			if (hit(wr, paddr, `TMRSQ_MASK))
				mask <= pwdata[1:0];
		end
	end

	// ==========================================
	// input synchronisers and prescaler
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ev_sync   <= 3'h0;
			sub_sync  <= 3'h0;
			ev_level  <= 1'b0;
			sub_level <= 1'b0;
			pre       <= 7'h00;
			stop_q    <= 1'b0;
		end else begin
			ev_sync  <= {ev_sync[1:0], event_input_pin};
			sub_sync <= {sub_sync[1:0], sub_clk_pin};
			ev_level  <= settled(ev_sync, ev_level);
			sub_level <= settled(sub_sync, sub_level);
			pre    <= pre + 7'h01;
			stop_q <= stop_mode;
		end
	end

	// ==========================================
	// free-running counter and read buffer
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt16      <= `TMRSQ_CNT16_RST;
			rd_buf     <= `TMRSQ_CNT16_RST;
			frozen     <= 1'b0;
			undef_flag <= 1'b0;
		end else begin
			// counting carries on in stop; there is deliberately no clear
			if (tick16)
				cnt16 <= cnt16 + 16'h0001;
			// the buffer follows the live count, so freezing needs no separate capture
			rd_buf <= view;
			if (hit(setup & ~pwrite, paddr, `TMRSQ_FRC_LO))
				frozen <= 1'b1;
			else if (hit(rd, paddr, `TMRSQ_FRC_HI))
				frozen <= 1'b0;
			// a lone low read leaves the buffer frozen until a high read
			if (stop_q && !stop_mode)
				undef_flag <= 1'b1;
			else if (clr_und)
				undef_flag <= 1'b0;
		end
	end

	// ==========================================
	// timer A: square wave on square_out_pin
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_a          <= `TMRSQ_CNT8_RST;
			match_a_q      <= 1'b0;
			square_out_pin <= 1'b0;
		end else if (!ctrl[`TMRSQ_EN_A]) begin
			cnt_a          <= `TMRSQ_CNT8_RST;
			match_a_q      <= 1'b0;
			square_out_pin <= 1'b0;
		end else if (tick_a) begin
			cnt_a     <= nx_a[7:0];
			match_a_q <= nx_a[8];
			if (nx_a[8] && ctrl[`TMRSQ_OE_A])
				square_out_pin <= ~square_out_pin;
		end else
			match_a_q <= 1'b0;
	end

	// ==========================================
	// timer B: event timer, square wave on square_out_pin_b
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_b            <= `TMRSQ_CNT8_RST;
			match_b_q        <= 1'b0;
			square_out_pin_b <= 1'b0;
		end else if (!ctrl[`TMRSQ_EN_B]) begin
			cnt_b            <= `TMRSQ_CNT8_RST;
			match_b_q        <= 1'b0;
			square_out_pin_b <= 1'b0;
		end else if (tick_b) begin
			cnt_b     <= nx_b[7:0];
			match_b_q <= nx_b[8];
			if (nx_b[8] && ctrl[`TMRSQ_OE_B])
				square_out_pin_b <= ~square_out_pin_b;
		end else
			match_b_q <= 1'b0;
	end

	// ==========================================
	// interrupts: sticky status, read clears, a new event wins over the clear
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ist <= 2'h0;
			irq <= 1'b0;
		end else begin
			ist <= next_ist;
			irq <= |(next_ist & mask);
		end
	end

endmodule // tmrsq_top

// >>> test/tmrsq_sva.sv
// port assertions for the timer group
`timescale 1ns/1ps
`include "tmrsq_regs.vh"
module tmrsq_sva (
	input wire        pclk,
	input wire        presetn,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [7:0]  paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire        pready,
	input wire        pslverr,
	input wire        square_out_pin,
	input wire        irq
);
	reg  [11:0] ctl;
	reg  [7:0]  cmp;
	reg  [1:0]  msk;
	wire        wr  = psel && penable && pready && pwrite;
	wire        bad = paddr > 8'h1C || paddr[1:0] != 2'h0;
	wire        run = ctl[1:0] == 2'h3 && ctl[4:2] == 3'h0 && cmp == 8'h03;
	// ==========================================
	// shadow of the settings, so pin behaviour can be tied to them
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl <= 12'h200;
			cmp <= 8'hFF;
			msk <= 2'h0;
		end else if (wr) begin
			if (paddr == `TMRSQ_CTRL)
				ctl <= pwdata[11:0];
			if (paddr == `TMRSQ_CMP)
				cmp <= pwdata[7:0];
			if (paddr == `TMRSQ_MASK)
				msk <= pwdata[1:0];
		end
	end
	// ==========================================
	// assertions
	default clocking dc @(posedge pclk); endclocking
	default disable iff (!presetn);
	ready_up_a: assert property ($past(presetn) |-> pready) else $error("ready low");
	err_bad_a: assert property (psel && penable && bad |-> pslverr) else $error("no err");
	err_good_a: assert property (psel && penable && !bad |-> !pslverr) else $error("err");
	rdata_idle_a: assert property (!psel && !$past(psel) |-> prdata == 32'h0)
		else $error("rdata idle");
	irq_mask_a: assert property (irq |-> msk != 2'h0 || $past(msk) != 2'h0)
		else $error("irq masked");
	out_off_a: assert property (!ctl[0] && !$past(ctl[0]) |-> !square_out_pin)
		else $error("out not low");
	half_low_a: assert property ($fell(square_out_pin) && run |->
		(!square_out_pin)[*4] ##1 square_out_pin) else $error("half period");
	match_irq_a: assert property ($fell(square_out_pin) && run && msk[0] |->
		##[1:4] irq) else $error("no irq");
endmodule // tmrsq_sva
bind tmrsq_top tmrsq_sva sva_u (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .square_out_pin(square_out_pin), .irq(irq));

// >>> test/tmrsq_pins.sv
// pin partner: free-running subclock and gated event pulses
`timescale 1ns/1ps
module tmrsq_pins (
	input wire pclk,
	input wire presetn,
	input wire ev_run,
	output reg sub_clk_pin,
	output reg event_input_pin
);
	reg [3:0] sc;
	reg [1:0] ec;
	// ==========================================
	// event pin is pulled down while no events come
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sc <= 4'h0;
			ec <= 2'h0;
			sub_clk_pin <= 1'b0;
			event_input_pin <= 1'b0;
		end else begin
			sc <= (sc == 4'h5) ? 4'h0 : sc + 4'h1;
			if (sc == 4'h5)
				sub_clk_pin <= !sub_clk_pin;
			ec <= (ec == 2'h2 || !ev_run) ? 2'h0 : ec + 2'h1;
			if (!ev_run)
				event_input_pin <= 1'b0;
			else if (ec == 2'h2)
				event_input_pin <= !event_input_pin;
		end
	end
endmodule // tmrsq_pins

// >>> test/testbench.sv
// self-checking testbench for the timer group
`timescale 1ns/1ps
`include "tmrsq_regs.vh"
module testbench;
	reg         pclk = 1'b0;
	reg         presetn = 1'b0;
	reg         psel = 1'b0;
	reg         penable = 1'b0;
	reg         pwrite = 1'b0;
	reg  [7:0]  paddr = 8'h00;
	reg  [31:0] pwdata = 32'h0;
	reg         stop_mode = 1'b0;
	reg         ev_run = 1'b0;
	wire [31:0] prdata;
	wire        pready;
	wire        pslverr;
	wire        sub_clk_pin;
	wire        event_input_pin;
	wire        square_out_pin;
	wire        square_out_pin_b;
	wire        irq;
	integer     errors = 0;
	integer     checked = 0;
	integer     n;
	integer     i;
	integer     hx [0:8];
	integer     bx [0:2];
	integer     evn = 0;
	reg  [31:0] rd;
	reg  [31:0] lo;
	reg         er;
	always #25 pclk = ~pclk;
	// events really sent, the reference for the 24-bit count
	always @(posedge event_input_pin) evn <= evn + 1;
	tmrsq_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .stop_mode(stop_mode), .sub_clk_pin(sub_clk_pin),
		.event_input_pin(event_input_pin), .square_out_pin(square_out_pin),
		.square_out_pin_b(square_out_pin_b), .irq(irq));
	tmrsq_pins pins_u (.pclk(pclk), .presetn(presetn), .ev_run(ev_run),
		.sub_clk_pin(sub_clk_pin), .event_input_pin(event_input_pin));
	task end_sim;
		begin
			$display("checked %0d errors %0d", checked, errors);
			if (errors == 0 && checked > 0)
				$display("TB: PASS");
			else
				$display("TB: FAIL");
			$finish;
		end
	endtask
	task chk(input [31:0] got, input [31:0] exp);
		begin
			checked = checked + 1;
			if (got !== exp) begin
				errors = errors + 1;
				$display("[ERR] %0t got %h exp %h", $time, got, exp);
			end
		end
	endtask
	task apb(input w, input [7:0] a, input [31:0] d);
		integer k;
		begin
			@(posedge pclk);
			psel <= 1'b1;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge pclk);
			penable <= 1'b1;
			@(posedge pclk);
			for (k = 0; pready !== 1'b1; k = k + 1) begin
				if (k == 50)
					chk(0, 1);
				if (k == 50)
					end_sim;
				@(posedge pclk);
			end
			rd = prdata;
			er = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask
	// waits until the chosen pin shows level v, with a bound
	task wait_pin(input b, input v);
		integer k;
		begin
			for (k = 0; (b ? square_out_pin_b : square_out_pin) !== v; k = k + 1) begin
				if (k == 3000)
					chk(0, 1);
				if (k == 3000)
					end_sim;
				@(posedge pclk);
			end
		end
	endtask
	// ends on a rising edge so a following stop never cuts a low phase short
	task measure(input b, output integer h);
		begin
			wait_pin(b, 0);
			wait_pin(b, 1);
			for (h = 0; (b ? square_out_pin_b : square_out_pin) === 1'b1; h = h + 1)
				@(posedge pclk);
			wait_pin(b, 1);
		end
	endtask
	initial begin
		hx[0] = 4;
		hx[1] = 32;
		hx[2] = 512;
		hx[3] = 48;
		hx[4] = 48;
		hx[5] = 96;
		hx[6] = 16;
		hx[7] = 256;
		hx[8] = 8;
		bx[0] = 32'h300;
		bx[1] = 32'h3C0;
		bx[2] = 32'hB00;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, `TMRSQ_FRC_W, 0);
		chk(rd < 32'd8, 1);
		apb(0, `TMRSQ_CTRL, 0);
		chk(rd, 32'h200);
		apb(0, `TMRSQ_CMP, 0);
		chk(rd, 32'hFFFF);
		apb(0, 8'h20, 0);
		chk(er, 1);
		apb(0, `TMRSQ_FRC_LO, 0);
		lo = rd;
		apb(0, `TMRSQ_STATUS, 0);
		chk(rd[18], 1);
		repeat (14) @(posedge pclk);
		apb(0, `TMRSQ_FRC_HI, 0);
		lo = {rd[7:0], lo[7:0]};
		apb(0, `TMRSQ_STATUS, 0);
		chk(rd[18], 0);
		apb(0, `TMRSQ_FRC_W, 0);
		chk({16'h0, rd[15:0] - lo[15:0]}, 32'd26);
		stop_mode <= 1'b1;
		repeat (3) @(posedge pclk);
		stop_mode <= 1'b0;
		apb(0, `TMRSQ_STATUS, 0);
		chk(rd[19], 1);
		apb(0, `TMRSQ_STATUS, 0);
		chk(rd[19], 0);
		apb(1, `TMRSQ_MASK, 1);
		apb(1, `TMRSQ_CMP, 32'h0103);
		ev_run <= 1'b1;
		apb(1, `TMRSQ_CTRL, 32'h360);
		measure(1, n);
		chk(n, 12);
		for (i = 0; i < 6; i = i + 1) begin
			apb(1, `TMRSQ_CTRL, 32'h362 | (i << 2));
			apb(1, `TMRSQ_CTRL, 32'h363 | (i << 2));
			measure(0, n);
			chk(n, hx[i]);
			apb(1, `TMRSQ_CTRL, 32'h362 | (i << 2));
		end
		repeat (3) @(posedge pclk);
		chk(square_out_pin, 0);
		chk(irq, 1);
		apb(0, `TMRSQ_IST, 0);
		chk(rd[0], 1);
		repeat (30) @(posedge pclk);
		chk(irq, 0);
		apb(0, `TMRSQ_IST, 0);
		chk(rd[1:0], 2'h2);
		apb(1, `TMRSQ_MASK, 2);
		repeat (30) @(posedge pclk);
		chk(irq, 1);
		apb(1, `TMRSQ_MASK, 0);
		repeat (3) @(posedge pclk);
		chk(irq, 0);
		apb(1, `TMRSQ_CTRL, 32'h340);
		// 16-bit counter on fx/8 and fx/128: setup edges 16 and 256 apart
		for (i = 0; i < 2; i = i + 1) begin
			apb(1, `TMRSQ_CTRL, 32'h400 + (i << 9));
			apb(0, `TMRSQ_FRC_W, 0);
			lo = rd;
			repeat (i ? 253 : 13) @(posedge pclk);
			apb(0, `TMRSQ_FRC_W, 0);
			chk({16'h0, rd[15:0] - lo[15:0]}, 32'd2);
		end
		// timer B on fx/8, fx/128 and on timer A matches
		for (i = 0; i < 3; i = i + 1) begin
			apb(1, `TMRSQ_CTRL, bx[i]);
			apb(1, `TMRSQ_CTRL, bx[i] | 32'h21);
			measure(1, n);
			chk(n, hx[6 + i]);
			apb(1, `TMRSQ_CTRL, bx[i]);
		end
		// 24-bit event counter: 16-bit counter on B matches, B on the event pin
		ev_run <= 1'b0;
		apb(1, `TMRSQ_CTRL, 32'h080);
		apb(1, `TMRSQ_CMP, 32'hFF03);
		apb(0, `TMRSQ_FRC_W, 0);
		lo = rd;
		apb(1, `TMRSQ_CTRL, 32'h0A0);
		n = evn;
		ev_run <= 1'b1;
		repeat (1850) @(posedge pclk);
		ev_run <= 1'b0;
		repeat (12) @(posedge pclk);
		n = evn - n;
		apb(0, `TMRSQ_FRC_W, 0);
		lo = ((rd - lo) & 32'hFFFF) << 8;
		apb(0, `TMRSQ_STATUS, 0);
		chk(lo | rd[15:8], n);
		end_sim;
	end
endmodule // testbench
